// File: design/prs_task_ctrl.sv
// Purpose: Runs the swap-to-sink and swap-to-source tasks of a PD port.
// Assumes: Policy engine flags a safe moment on pe_ready.
// Notes: Result byte lands in the buffer one cycle before the command clears.
`timescale 1ns/100ps
`include "prs_consts.svh"

// Functional notes
// RULE1 - Sink task sends a power role swap at the first safe moment.
// RULE2 - Source task sends a power role swap at the first safe moment.
// RULE3 - Result code goes to buffer byte zero; tasks take no input.
// RULE4 - Sink task ends only on completion, impossibility or failure.
// RULE5 - Source task ends only on completion, impossibility or failure.
// RULE6 - Sink task keeps running while the partner answers Wait.
// RULE7 - Source task keeps running while the partner answers Wait.
// RULE8 - Sink task rejected when partner source caps lack dual-role power.
// RULE9 - Source task rejected when partner caps showed no dual-role power.
// RULE10 - Either task rejected when the partner rejects the swap.
// RULE11 - Accepted swap that fails to complete ends as timed out.
// RULE12 - Sink task succeeds at once when already sink.
// RULE13 - Source task succeeds at once when already source.
// RULE14 - Accepted swap that completes normally ends as success.
// RULE15 - After sink success the role output shows sink.
// RULE16 - After source success the role output shows source.
// RULE17 - Failure after accept requests a soft reset.
// RULE18 - Low nibble: zero success, one timeout or abort, three reject.
// RULE19 - Result written before the command register clears.
// RULE20 - Buffer untouched by the device while the command reads zero.
// RULE21 - Host writes the code, polls for zero, then reads the result.
module prs_task_ctrl
  import prs_pkg::*;
#(
  parameter int TW = 24,
  parameter int DEPTH = 64,
  parameter int AW = 6,
  parameter int RESP_TMO_CYC = `PRS_US_TO_CYC(`PRS_RESP_TMO_US),
  parameter int SWAP_TMO_CYC = `PRS_US_TO_CYC(`PRS_SWAP_TMO_US),
  parameter int BACKOFF_CYC = `PRS_US_TO_CYC(`PRS_WAIT_BACKOFF_US)
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cmd_wr,
  input wire logic [31:0] cmd_wdata,
  output logic [31:0] cmd_rdata,
  input wire logic abort_task_request,
  input wire logic buf_wr,
  input wire logic [AW-1:0] buf_waddr,
  input wire logic [7:0] buf_wdata,
  input wire logic [AW-1:0] buf_raddr,
  output logic [7:0] task_data_buffer,
  input wire logic role_init_src,
  input wire logic partner_caps_known,
  input wire logic partner_drp,
  input wire logic pe_ready,
  input wire prs_msg_e rx_msg,
  input wire logic swap_complete,
  input wire logic swap_fail,
  output logic power_role_src,
  output logic swap_req,
  output logic soft_rst_req,
  output logic task_busy
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    prs_state_e state;
    logic [31:0] cmd;
    logic role_src;
    logic role_loaded;
    logic target_src;
    logic [3:0] result;
    logic swap_req;
    logic soft_rst;
    logic tmr_go;
    logic [TW-1:0] tmr_len;
    logic buf_we;
    logic busy;
  } prs_top_s;

  prs_top_s cur_ff;
  prs_top_s nxt_st;
  logic tmr_exp;

  // ****************************************
  // Sequencer
  // ****************************************
  // Strobes default low so each lasts one cycle.
  always_comb
  begin
    nxt_st = cur_ff;
    nxt_st.swap_req = 1'b0;
    nxt_st.soft_rst = 1'b0;
    nxt_st.tmr_go = 1'b0;
    nxt_st.buf_we = 1'b0;
    // Role is caught once after reset release, not under reset.
    if (!cur_ff.role_loaded)
    begin
      nxt_st.role_src = role_init_src;
      nxt_st.role_loaded = 1'b1;
    end
    unique case (cur_ff.state)
      PRS_IDLE:
      begin
        // Only a write while idle starts a task; the host must poll.
        if (cmd_wr && (cmd_wdata != `PRS_CMD_IDLE))
        begin
          nxt_st.cmd = cmd_wdata;
          if (cmd_wdata == `PRS_CMD_TO_SINK)
          begin
            nxt_st.target_src = 1'b0;
            nxt_st.state = PRS_CHECK;
          end
          else if (cmd_wdata == `PRS_CMD_TO_SOURCE)
          begin
            nxt_st.target_src = 1'b1;
            nxt_st.state = PRS_CHECK;
          end
          else
            nxt_st.cmd = `PRS_CMD_UNKNOWN;
        end
      end
      PRS_CHECK:
      begin
        // RULE12 already sink
        // RULE13 already source
        if (cur_ff.role_src == cur_ff.target_src)
        begin
          nxt_st.result = `PRS_RES_OK;
          nxt_st.state = PRS_FIN_WR;
        end
        // RULE8 no DRP sink
        // RULE9 no DRP source
        else if (partner_caps_known && !partner_drp)
        begin
          nxt_st.result = `PRS_RES_REJECT;
          nxt_st.state = PRS_FIN_WR;
        end
        else if (abort_task_request)
        begin
          nxt_st.result = `PRS_RES_TIMEOUT;
          nxt_st.state = PRS_FIN_WR;
        end
        else
          nxt_st.state = PRS_WAIT_OPP;
      end
      PRS_WAIT_OPP:
      begin
        if (abort_task_request)
        begin
          nxt_st.result = `PRS_RES_TIMEOUT;
          nxt_st.state = PRS_FIN_WR;
        end
        // RULE1 sink first opportunity
        // RULE2 source first opportunity
        else if (pe_ready)
        begin
          nxt_st.swap_req = 1'b1;
          nxt_st.tmr_go = 1'b1;
          nxt_st.tmr_len = TW'(RESP_TMO_CYC);
          nxt_st.state = PRS_WAIT_RESP;
        end
      end
      PRS_WAIT_RESP:
      begin
        if (rx_msg == PRS_MSG_ACCEPT)
        begin
          nxt_st.tmr_go = 1'b1;
          nxt_st.tmr_len = TW'(SWAP_TMO_CYC);
          nxt_st.state = PRS_SWAPPING;
        end
        // RULE10 partner rejects
        else if (rx_msg == PRS_MSG_REJECT)
        begin
          nxt_st.result = `PRS_RES_REJECT;
          nxt_st.state = PRS_FIN_WR;
        end
        // RULE6 sink wait retry
        // RULE7 source wait retry
        else if (rx_msg == PRS_MSG_WAIT)
        begin
          nxt_st.tmr_go = 1'b1;
          nxt_st.tmr_len = TW'(BACKOFF_CYC);
          nxt_st.state = PRS_BACKOFF;
        end
        else if (tmr_exp || abort_task_request)
        begin
          nxt_st.result = `PRS_RES_TIMEOUT;
          nxt_st.state = PRS_FIN_WR;
        end
      end
      PRS_BACKOFF:
      begin
        if (abort_task_request)
        begin
          nxt_st.result = `PRS_RES_TIMEOUT;
          nxt_st.state = PRS_FIN_WR;
        end
        else if (tmr_exp)
          nxt_st.state = PRS_WAIT_OPP;
      end
      PRS_SWAPPING:
      begin
        // RULE14 normal completion
        // RULE15 role now sink
        // RULE16 role now source
        if (swap_complete)
        begin
          nxt_st.role_src = cur_ff.target_src;
          nxt_st.result = `PRS_RES_OK;
          nxt_st.state = PRS_FIN_WR;
        end
        // RULE11 accepted then failed
        // RULE17 soft reset request
        else if (swap_fail || tmr_exp || abort_task_request)
        begin
          nxt_st.soft_rst = 1'b1;
          nxt_st.result = `PRS_RES_TIMEOUT;
          nxt_st.state = PRS_FIN_WR;
        end
      end
      PRS_FIN_WR:
      begin
        // The result write strobe is raised from the next state below.
        nxt_st.state = PRS_FIN_CLR;
      end
      PRS_FIN_CLR:
      begin
        // RULE19 clear after write
        // RULE4 sink task ends
        // RULE5 source task ends
        nxt_st.cmd = `PRS_CMD_IDLE;
        nxt_st.state = PRS_IDLE;
      end
      default:
        nxt_st.state = PRS_IDLE;
    endcase
    // RULE3 RULE19 write then clear
    // Writing during FIN_WR leaves a whole cycle before the command clears.
    nxt_st.buf_we = (nxt_st.state == PRS_FIN_WR);
    nxt_st.busy = (nxt_st.state != PRS_IDLE);
  end

  // State register; role comes from the strap one cycle after release.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cur_ff <= '0;
      cur_ff.state <= PRS_IDLE;
    end
    else
      cur_ff <= nxt_st;
  end

  // ****************************************
  // Helpers
  // ****************************************
  // Reserved upper nibble stays zero for these tasks.
  // RULE18 result low nibble
  logic [7:0] res_byte;
  assign res_byte = {4'h0, cur_ff.result};

  prs_timer #(
    .W(TW)
  ) u_timer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .start(cur_ff.tmr_go),
    .load(cur_ff.tmr_len),
    .expired(tmr_exp)
  );

  // RULE20 device writes gated
  prs_data_buf #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_buf (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .host_we(buf_wr),
    .host_waddr(buf_waddr),
    .host_wdata(buf_wdata),
    .dev_we(cur_ff.buf_we),
    .dev_waddr(AW'(`PRS_RES_BYTE_ADDR)),
    .dev_wdata(res_byte),
    .raddr(buf_raddr),
    .rdata(task_data_buffer)
  );

  assign cmd_rdata = cur_ff.cmd;
  assign power_role_src = cur_ff.role_src;
  assign swap_req = cur_ff.swap_req;
  assign soft_rst_req = cur_ff.soft_rst;
  assign task_busy = cur_ff.busy;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_finish;
    cur_ff.buf_we ##2 (cur_ff.cmd == `PRS_CMD_IDLE);
  endsequence

  sequence s_reject_end;
    (cur_ff.state == PRS_FIN_WR) && (cur_ff.result == `PRS_RES_REJECT) ##0 s_finish;
  endsequence

  AST_WRITE_BEFORE_CLEAR: assert property ( // RULE19
    $changed(cur_ff.cmd) && (cur_ff.cmd == `PRS_CMD_IDLE) |-> $past(cur_ff.buf_we, 2))
    else $error("Command cleared without a result write.");

  AST_NO_WRITE_WHEN_IDLE: assert property ( // RULE20
    (cur_ff.cmd == `PRS_CMD_IDLE) |-> !cur_ff.buf_we)
    else $error("Buffer written while the command reads zero.");

  AST_SAME_ROLE_OK: assert property ( // RULE12
    (cur_ff.state == PRS_CHECK) && (cur_ff.role_src == cur_ff.target_src)
    |-> ##1 (cur_ff.result == `PRS_RES_OK) && !swap_req ##0 s_finish)
    else $error("Same-role task did not succeed at once.");

  AST_NO_DRP_REJECT: assert property ( // RULE8
    (cur_ff.state == PRS_CHECK) && (cur_ff.role_src != cur_ff.target_src)
    && partner_caps_known && !partner_drp |-> ##1 s_reject_end)
    else $error("Missing dual-role support not rejected.");

  AST_PARTNER_REJECT: assert property ( // RULE10
    (cur_ff.state == PRS_WAIT_RESP) && (rx_msg == PRS_MSG_REJECT) |-> ##1 s_reject_end)
    else $error("Partner reject not reported as rejected.");

  AST_FAIL_SOFT_RESET: assert property ( // RULE17
    (cur_ff.state == PRS_SWAPPING) && !swap_complete && swap_fail
    |-> ##1 soft_rst_req && (cur_ff.result == `PRS_RES_TIMEOUT) ##1 !soft_rst_req)
    else $error("Failed swap did not request a soft reset.");

  AST_WAIT_STAYS_BUSY: assert property ( // RULE6
    (cur_ff.state == PRS_WAIT_RESP) && (rx_msg == PRS_MSG_WAIT) && !abort_task_request
    |-> ##1 (cur_ff.state == PRS_BACKOFF) && task_busy && (cur_ff.cmd != `PRS_CMD_IDLE))
    else $error("Wait answer ended the task.");

  AST_SUCCESS_ROLE: assert property ( // RULE14
    (cur_ff.state == PRS_SWAPPING) && swap_complete
    |-> ##1 (power_role_src == cur_ff.target_src) && (cur_ff.result == `PRS_RES_OK))
    else $error("Completed swap did not set the role.");

  AST_REQ_AFTER_READY: assert property ( // RULE1
    swap_req |-> $past(pe_ready) && (cur_ff.state == PRS_WAIT_RESP))
    else $error("Swap request sent without a safe moment.");

  AST_END_ONLY_FINISH: assert property ( // RULE4
    $fell(task_busy) |-> $past(cur_ff.state == PRS_FIN_CLR))
    else $error("Task ended outside its finish step.");

endmodule

// File: design/prs_consts.svh
// Purpose: Constants of the power role swap task block.
// Assumes: core_clk at 250 MHz.
// Notes: Times are given in their own unit; cycle counts derive from them.
`ifndef PRS_CONSTS_SVH
`define PRS_CONSTS_SVH

// ****************************************
// Task codes and clock
// ****************************************
`define PRS_CMD_IDLE 32'h0000_0000
`define PRS_CMD_TO_SINK 32'h5357_536B
`define PRS_CMD_TO_SOURCE 32'h5357_5372
`define PRS_CMD_UNKNOWN 32'h444D_4321
`define PRS_CLK_PERIOD_NS 4

// ****************************************
// Result byte layout
// ****************************************
`define PRS_RES_LSB 0
`define PRS_RES_OK 4'h0
`define PRS_RES_TIMEOUT 4'h1
`define PRS_RES_REJECT 4'h3
`define PRS_RES_BYTE_ADDR 6'h00

// ****************************************
// Timing, least times rounded up
// ****************************************
`define PRS_RESP_TMO_US 100
`define PRS_SWAP_TMO_US 1000
`define PRS_WAIT_BACKOFF_US 50
`define PRS_US_TO_CYC(t) (((t) * 1000 + `PRS_CLK_PERIOD_NS - 1) / `PRS_CLK_PERIOD_NS)

`endif

// File: design/prs_pkg.sv
// Purpose: Types of the power role swap task block.
// Assumes: Included constants file holds all numbers.
// Notes: Enums carry no explicit codes.
package prs_pkg;

  // Task sequencer states.
  typedef enum logic [3:0] {
    PRS_IDLE,
    PRS_CHECK,
    PRS_WAIT_OPP,
    PRS_WAIT_RESP,
    PRS_BACKOFF,
    PRS_SWAPPING,
    PRS_FIN_WR,
    PRS_FIN_CLR
  } prs_state_e;

  // Answer of the port partner to a swap request.
  typedef enum logic [1:0] {
    PRS_MSG_NONE,
    PRS_MSG_ACCEPT,
    PRS_MSG_REJECT,
    PRS_MSG_WAIT
  } prs_msg_e;

endpackage

// File: design/prs_timer.sv
// Purpose: One-shot down counter for response, backoff and swap limits.
// Assumes: A new start reloads the count and cancels the old one.
// Notes: Expiry is a one-cycle registered pulse.
`timescale 1ns/100ps
module prs_timer
  import prs_pkg::*;
#(
  parameter int W = 24
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [W-1:0] load,
  output logic expired
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic run;
    logic exp;
  } prs_tmr_s;

  prs_tmr_s cur_ff;
  prs_tmr_s nxt_tmr;

  // Count down while running; a fresh start always wins.
  always_comb
  begin
    nxt_tmr = cur_ff;
    nxt_tmr.exp = 1'b0;
    if (start)
    begin
      nxt_tmr.cnt = load;
      nxt_tmr.run = 1'b1;
    end
    else if (cur_ff.run)
    begin
      if (cur_ff.cnt <= W'(1))
      begin
        nxt_tmr.run = 1'b0;
        nxt_tmr.exp = 1'b1;
      end
      nxt_tmr.cnt = cur_ff.cnt - W'(1);
    end
  end

  // State register.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      cur_ff <= '0;
    else
      cur_ff <= nxt_tmr;
  end

  // A pulse left over from an earlier count is masked in the cycle of a new start,
  // so a fresh limit never ends at once.
  assign expired = cur_ff.exp && !start;

endmodule

// File: design/prs_data_buf.sv
// Purpose: Byte-wide task data buffer shared by host and sequencer.
// Assumes: Sequencer writes only while a task runs.
// Notes: The sequencer write wins over a host write in the same cycle.
`timescale 1ns/100ps
module prs_data_buf
  import prs_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int AW = 6
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic host_we,
  input wire logic [AW-1:0] host_waddr,
  input wire logic [7:0] host_wdata,
  input wire logic dev_we,
  input wire logic [AW-1:0] dev_waddr,
  input wire logic [7:0] dev_wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [7:0] rd;
  } prs_buf_s;

  prs_buf_s cur_ff;
  prs_buf_s nxt_buf;

  // One write port after arbitration; read data is registered.
  always_comb
  begin
    nxt_buf = cur_ff;
    nxt_buf.rd = cur_ff.mem[raddr];
    if (dev_we)
      nxt_buf.mem[dev_waddr] = dev_wdata;
    else if (host_we)
      nxt_buf.mem[host_waddr] = host_wdata;
  end

  // State register.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      cur_ff <= '0;
    else
      cur_ff <= nxt_buf;
  end

  assign rdata = cur_ff.rd;

endmodule

// File: tb/prs_pd_partner.sv
// Purpose: Behavioural port partner answering power role swap requests.
// Assumes: Answers start on the edge that samples swap_req high.
// Notes: mode 0 accept and complete, 1 accept and fail, 2 reject, 4 silent.
`timescale 1ns/100ps
module prs_pd_partner
  import prs_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic swap_req,
  input wire logic [2:0] mode,
  input wire logic [1:0] n_wait,
  input wire logic [3:0] dly,
  output prs_msg_e rx_msg,
  output logic swap_complete,
  output logic swap_fail
);
  // ****************************************
  // Answer sequencer
  // ****************************************
  int w;
  logic acc;

  // Each message lasts one cycle; a slow partner waits dly edges before it.
  initial
  begin
    rx_msg = PRS_MSG_NONE;
    swap_complete = 1'b0;
    swap_fail = 1'b0;
    w = 0;
    forever
    begin
      @(posedge core_clk);
      if (sys_rst)
        w = 0;
      else if (swap_req === 1'b1 && mode != 3'd4)
      begin
        repeat (dly) @(posedge core_clk);
        acc = 1'b0;
        if (w < n_wait)
        begin
          w++;
          rx_msg <= PRS_MSG_WAIT;
        end
        else
        begin
          w = 0;
          acc = (mode != 3'd2);
          rx_msg <= acc ? PRS_MSG_ACCEPT : PRS_MSG_REJECT;
        end
        @(posedge core_clk);
        rx_msg <= PRS_MSG_NONE;
        if (acc)
        begin
          repeat (3) @(posedge core_clk);
          swap_complete <= (mode == 3'd0);
          swap_fail <= (mode == 3'd1);
          @(posedge core_clk);
          swap_complete <= 1'b0;
          swap_fail <= 1'b0;
        end
      end
    end
  end
endmodule

// File: tb/test_power_role_swap_tasks.sv
// Purpose: Self-checking bench of the swap-to-sink and swap-to-source tasks.
// Assumes: Short timeouts of 20, 50 and 10 cycles keep the run brief.
// Notes: Byte 0 is preloaded before each task so a missing result shows.
`timescale 1ns/100ps
`include "prs_consts.svh"
module test_power_role_swap_tasks
  import prs_pkg::*;
;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic core_clk, sys_rst, cmd_wr, abort_task_request, buf_wr, pe_ready;
  logic partner_caps_known, partner_drp, role_init_src;
  logic [5:0] buf_waddr, buf_raddr;
  logic [31:0] cmd_wdata, cmd_rdata;
  logic [7:0] buf_wdata, task_data_buffer;
  logic swap_complete, swap_fail, power_role_src, swap_req, soft_rst_req, task_busy;
  prs_msg_e rx_msg;
  logic [2:0] mode;
  logic [1:0] n_wait;
  logic [3:0] dly;
  int error_cnt, tests_run, swp_cnt, srst_cnt;

  prs_task_ctrl #(.RESP_TMO_CYC(20), .SWAP_TMO_CYC(50), .BACKOFF_CYC(10)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata),
    .cmd_rdata(cmd_rdata), .abort_task_request(abort_task_request), .buf_wr(buf_wr),
    .buf_waddr(buf_waddr), .buf_wdata(buf_wdata), .buf_raddr(buf_raddr),
    .task_data_buffer(task_data_buffer), .role_init_src(role_init_src),
    .partner_caps_known(partner_caps_known), .partner_drp(partner_drp),
    .pe_ready(pe_ready), .rx_msg(rx_msg), .swap_complete(swap_complete),
    .swap_fail(swap_fail), .power_role_src(power_role_src), .swap_req(swap_req),
    .soft_rst_req(soft_rst_req), .task_busy(task_busy));

  prs_pd_partner peer (
    .core_clk(core_clk), .sys_rst(sys_rst), .swap_req(swap_req), .mode(mode),
    .n_wait(n_wait), .dly(dly), .rx_msg(rx_msg), .swap_complete(swap_complete),
    .swap_fail(swap_fail));

  // Clock of 4 ns period.
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Pulse counters; outputs are registered so they are stable at the edge.
  always @(posedge core_clk)
  begin
    if (swap_req === 1'b1) swp_cnt++;
    if (soft_rst_req === 1'b1) srst_cnt++;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One task run; go low holds the policy engine off and aborts instead.
  task automatic do_task(input logic [31:0] code, input logic known, input logic drp,
    input logic [2:0] md, input logic [1:0] nw, input logic [3:0] dl, input logic go,
    input logic [3:0] res, input logic role, input int swaps, input int srst);
    int i;
    begin
      @(posedge core_clk);
      swp_cnt = 0;
      srst_cnt = 0;
      partner_caps_known <= known;
      partner_drp <= drp;
      mode <= md;
      n_wait <= nw;
      dly <= dl;
      cmd_wr <= 1'b1;
      cmd_wdata <= code;
      buf_wr <= 1'b1;
      buf_wdata <= 8'hEE;
      pe_ready <= 1'b0;
      @(posedge core_clk);
      cmd_wr <= 1'b0;
      buf_wr <= 1'b0;
      #1;
      check(cmd_rdata === code, "command code not held");
      repeat (3) @(posedge core_clk);
      pe_ready <= go;
      abort_task_request <= ~go;
      @(posedge core_clk);
      abort_task_request <= 1'b0;
      #1;
      for (i = 0; i < 500 && cmd_rdata !== 32'h0000_0000; i++)
      begin
        @(posedge core_clk);
        #1;
      end
      check(i < 500, "task never completed");
      check(task_data_buffer === {4'h0, res}, "wrong result byte");
      check(task_busy === 1'b0, "busy after completion");
      check(power_role_src === role, "wrong power role");
      check(swp_cnt == swaps, "wrong swap request count");
      check(srst_cnt == srst, "wrong soft reset count");
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task sc_sink_same;
    do_task(`PRS_CMD_TO_SINK, 0, 0, 0, 0, 0, 1, `PRS_RES_OK, 0, 0, 0);
  endtask
  task sc_src_nodrp;
    do_task(`PRS_CMD_TO_SOURCE, 1, 0, 0, 0, 0, 1, `PRS_RES_REJECT, 0, 0, 0);
  endtask
  task sc_src_wait;
    do_task(`PRS_CMD_TO_SOURCE, 1, 1, 0, 2, 2, 1, `PRS_RES_OK, 1, 3, 0);
  endtask
  task sc_src_same;
    do_task(`PRS_CMD_TO_SOURCE, 1, 1, 0, 0, 0, 1, `PRS_RES_OK, 1, 0, 0);
  endtask
  task sc_sink_nodrp;
    do_task(`PRS_CMD_TO_SINK, 1, 0, 0, 0, 0, 1, `PRS_RES_REJECT, 1, 0, 0);
  endtask
  task sc_sink_rej;
    do_task(`PRS_CMD_TO_SINK, 1, 1, 2, 0, 0, 1, `PRS_RES_REJECT, 1, 1, 0);
  endtask
  task sc_sink_wait;
    do_task(`PRS_CMD_TO_SINK, 1, 1, 0, 1, 0, 1, `PRS_RES_OK, 0, 2, 0);
  endtask
  task sc_src_fail;
    do_task(`PRS_CMD_TO_SOURCE, 1, 1, 1, 0, 1, 1, `PRS_RES_TIMEOUT, 0, 1, 1);
  endtask
  task sc_src_silent;
    do_task(`PRS_CMD_TO_SOURCE, 1, 1, 4, 0, 0, 1, `PRS_RES_TIMEOUT, 0, 1, 0);
  endtask
  task sc_abort;
    do_task(`PRS_CMD_TO_SOURCE, 1, 1, 0, 0, 0, 0, `PRS_RES_TIMEOUT, 0, 0, 0);
  endtask

  // An unknown code runs nothing and answers with the refusal code.
  task sc_unknown;
    begin
      @(posedge core_clk);
      cmd_wr <= 1'b1;
      cmd_wdata <= 32'h1234_5678;
      @(posedge core_clk);
      cmd_wr <= 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
      check(cmd_rdata === `PRS_CMD_UNKNOWN && task_busy === 1'b0, "unknown code");
    end
  endtask

  // A host preload of byte 1 after completion must survive untouched.
  task sc_keep;
    begin
      @(posedge core_clk);
      buf_wr <= 1'b1;
      buf_waddr <= 6'h01;
      buf_raddr <= 6'h01;
      buf_wdata <= 8'hA5;
      @(posedge core_clk);
      buf_wr <= 1'b0;
      buf_waddr <= 6'h00;
      repeat (20) @(posedge core_clk);
      #1;
      check(task_data_buffer === 8'hA5, "buffer changed while idle");
      @(posedge core_clk);
      buf_raddr <= 6'h00;
    end
  endtask

  // Mid-run reset with a source strap, then a plain swap from source to sink.
  task sc_reset_src;
    begin
      @(posedge core_clk);
      role_init_src <= 1'b1;
      sys_rst <= 1'b1;
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      check(power_role_src === 1'b1 && cmd_rdata === 32'h0 && task_busy === 1'b0, "reset state");
      do_task(`PRS_CMD_TO_SINK, 1, 1, 0, 0, 0, 1, `PRS_RES_OK, 0, 1, 0);
    end
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial
  begin
    sys_rst = 1'b1;
    {cmd_wr, abort_task_request, buf_wr, pe_ready} = 4'h0;
    {partner_caps_known, partner_drp} = 2'h0;
    role_init_src = 1'b0;
    buf_waddr = 6'h00;
    buf_raddr = 6'h00;
    cmd_wdata = 32'h0000_0000;
    buf_wdata = 8'h00;
    {mode, n_wait, dly} = 9'h000;
    {error_cnt, tests_run, swp_cnt, srst_cnt} = '0;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    sc_sink_same();
    sc_src_nodrp();
    sc_src_wait();
    sc_src_same();
    sc_sink_nodrp();
    sc_sink_rej();
    sc_sink_wait();
    sc_src_fail();
    sc_src_silent();
    sc_abort();
    sc_unknown();
    sc_keep();
    sc_reset_src();
    close_out();
  end

  // The tests need about 200 cycles; far beyond that counts as a hang.
  initial
  begin
    #60000;
    error_cnt++;
    close_out();
  end
endmodule
